// ### logic/cpx_expansion.sv
// coupled pwm state-machine expansion interface, top level
//
// Contract
// - pair unlock selection stays writable while units run.
// - mode 000 single, 001 sync pair, 010 two sync pairs, 011 two async, 100 ext, 101 async.
// - merged-drive clear gives each unit its own independent output.
// - unit active outside frozen state, inactive inside it.
// - pair active if one unit runs and other pair fully frozen.
// - single mode unit depends only on its own configuration; code still merges pin 2 through pair 0 while pair 0 is in two-pairs mode.
// - sync pair keeps exactly one unit active, alternating.
// - unit entering frozen state releases partner, active two periods later.
// - unit n couples with n+1 for n of 0, 2, 4.
// - both merged-drive bits clear gives separate outputs per unit.
// - single merged-drive bit makes that pin the OR of gated waveforms.
// - merged pin drops the frozen unit's level at handover, low while both are frozen.
// - two-pairs mode pairs units 0,1 and 2,3, outputs cross coupled.
// - handover by hold handshakes, plus pair-switch line for two pairs.
// - outputs 0 with 2 and 1 with 3 cross coupled, one pair active.
module cpx_expansion (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [cpx_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [cpx_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [cpx_pkg::DATA_W-1:0] reg_rdata_r,
  input wire logic [cpx_pkg::NUM_UNITS-1:0] unit_enable,
  input wire logic [3*cpx_pkg::NUM_UNITS-1:0] unit_state,
  input wire logic [cpx_pkg::NUM_UNITS-1:0] unit_pwm,
  input wire logic pair_switch,
  output logic [cpx_pkg::NUM_UNITS-1:0] pwm_out_r,
  output logic [cpx_pkg::NUM_UNITS-1:0] hold_release_handshake_r,
  output logic [cpx_pkg::NUM_UNITS-1:0] unit_coupled_r
);
  import cpx_pkg::*;

  // ********************************
  // configuration registers
  // ********************************
  logic [7:0] cfg_r [NUM_PAIRS];
  logic [2:0] unlock_r;
  logic [NUM_PAIRS-1:0] pair_busy;
  logic [NUM_PAIRS-1:0] cfg_wr;
  logic unlock_wr;

  assign unlock_wr = reg_wr & (reg_addr == ADDR_UNLOCK);

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PAIRS; gp++) begin : g_cfg
      // config frozen while either unit of the pair runs
      assign pair_busy[gp] = unit_enable[2*gp] | unit_enable[2*gp+1];
      assign cfg_wr[gp] = reg_wr & (reg_addr == ADDR_W'(gp)) & ~pair_busy[gp];
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          cfg_r[gp] <= CFG_RESET;
        end else if (cfg_wr[gp]) begin
          cfg_r[gp] <= reg_wdata;
        end
      end
    end
  endgenerate

  // unlock may change at any time
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      unlock_r <= UNLOCK_RESET;
    end else if (unlock_wr) begin
      unlock_r <= reg_wdata[2:0];
    end
  end

  // ********************************
  // mode decode and activity
  // ********************************
  logic [2:0] pair_mode [NUM_PAIRS];
  logic [NUM_UNITS-1:0] drv;
  logic [NUM_UNITS-1:0] hold;
  logic [NUM_UNITS-1:0] active;
  logic [NUM_PAIRS-1:0] coupled;
  logic [NUM_PAIRS-1:0] merge_ok;
  logic two_pairs;
  logic [1:0] pair_act;

  generate
    for (gp = 0; gp < NUM_PAIRS; gp++) begin : g_dec
      assign pair_mode[gp] = cfg_r[gp][CFG_MODE_LO_POS +: 3];
      assign drv[2*gp] = cfg_r[gp][CFG_DRV_LO_POS];
      assign drv[2*gp+1] = cfg_r[gp][CFG_DRV_HI_POS];
      // unit n couples only with n+1
      assign coupled[gp] = ~unlock_r[gp] & ((pair_mode[gp] == MODE_SYNC_PAIR) |
        (pair_mode[gp] == MODE_TWO_SYNC) | (pair_mode[gp] == MODE_TWO_ASYNC) |
        (pair_mode[gp] == MODE_ASYNC_PAIR));
      assign merge_ok[gp] = coupled[gp];
    end
  endgenerate

  generate
    for (gp = 0; gp < NUM_UNITS; gp++) begin : g_act
      assign hold[gp] = unit_state[3*gp +: 3] == STATE_HOLD;
      assign active[gp] = ~hold[gp];
    end
  endgenerate

  assign two_pairs = coupled[0] & ((pair_mode[0] == MODE_TWO_SYNC) | (pair_mode[0] == MODE_TWO_ASYNC));
  assign pair_act[0] = (active[0] | active[1]) & hold[2] & hold[3];
  assign pair_act[1] = (active[2] | active[3]) & hold[0] & hold[1];

  // ********************************
  // handover between partners
  // ********************************
  logic [NUM_PAIRS-1:0] allow;
  logic [NUM_PAIRS-1:0] ext_lo;
  logic [NUM_PAIRS-1:0] ext_hi;
  logic [NUM_PAIRS-1:0] first_lo;
  logic [NUM_PAIRS-1:0] leave;
  logic [NUM_UNITS-1:0] rel;

  // pair switch level picks the pair holding control
  assign allow[0] = ~two_pairs | ~pair_switch;
  assign allow[1] = ~two_pairs | pair_switch;
  assign allow[2] = 1'b1;
  // the unit of the next pair that froze first takes over
  assign ext_lo[0] = two_pairs & leave[1] & first_lo[0];
  assign ext_hi[0] = two_pairs & leave[1] & ~first_lo[0];
  assign ext_lo[1] = two_pairs & leave[0] & first_lo[1];
  assign ext_hi[1] = two_pairs & leave[0] & ~first_lo[1];
  assign ext_lo[2] = 1'b0;
  assign ext_hi[2] = 1'b0;

  generate
    for (gp = 0; gp < NUM_PAIRS; gp++) begin : g_hs
      cpx_handover u_hs (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .coupled(coupled[gp]),
        .allow(allow[gp]),
        .hold_lo(hold[2*gp]),
        .hold_hi(hold[2*gp+1]),
        .ext_rel_lo(ext_lo[gp]),
        .ext_rel_hi(ext_hi[gp]),
        .rel_lo_r(rel[2*gp]),
        .rel_hi_r(rel[2*gp+1]),
        .first_lo_r(first_lo[gp]),
        .leave(leave[gp])
      );
    end
  endgenerate

  // ********************************
  // output merging
  // ********************************
  logic [2:0] sa_idx [NUM_PAIRS];
  logic [2:0] sb_idx [NUM_PAIRS];
  logic [NUM_PAIRS-1:0] s_act_a;
  logic [NUM_PAIRS-1:0] s_act_b;
  logic [NUM_PAIRS-1:0] s_out_a;
  logic [NUM_PAIRS-1:0] s_out_b;
  logic [NUM_UNITS-1:0] pwm_nxt;

  // slots: two-pairs crosses 0 with 2 and 1 with 3
  assign sa_idx[0] = 3'h0;
  assign sb_idx[0] = two_pairs ? 3'h2 : 3'h1;
  assign sa_idx[1] = two_pairs ? 3'h1 : 3'h2;
  assign sb_idx[1] = 3'h3;
  assign sa_idx[2] = 3'h4;
  assign sb_idx[2] = 3'h5;
  assign s_act_a[0] = two_pairs ? pair_act[0] : active[0];
  assign s_act_b[0] = two_pairs ? pair_act[1] : active[1];
  assign s_act_a[1] = two_pairs ? pair_act[0] : active[2];
  assign s_act_b[1] = two_pairs ? pair_act[1] : active[3];
  assign s_act_a[2] = active[4];
  assign s_act_b[2] = active[5];

  generate
    for (gp = 0; gp < NUM_PAIRS; gp++) begin : g_mrg
      cpx_pair_merge u_mrg (
        .merge_en(merge_ok[gp]),
        .pwm_a(unit_pwm[sa_idx[gp]]),
        .pwm_b(unit_pwm[sb_idx[gp]]),
        .act_a(s_act_a[gp]),
        .act_b(s_act_b[gp]),
        .drv_a(drv[sa_idx[gp]]),
        .drv_b(drv[sb_idx[gp]]),
        .out_a(s_out_a[gp]),
        .out_b(s_out_b[gp])
      );
    end
  endgenerate

  assign pwm_nxt[0] = s_out_a[0];
  assign pwm_nxt[1] = two_pairs ? s_out_a[1] : s_out_b[0];
  assign pwm_nxt[2] = two_pairs ? s_out_b[0] : s_out_a[1];
  assign pwm_nxt[3] = s_out_b[1];
  assign pwm_nxt[4] = s_out_a[2];
  assign pwm_nxt[5] = s_out_b[2];

  // ********************************
  // register read and outputs
  // ********************************
  logic [DATA_W-1:0] rd_mux;
  logic [NUM_UNITS-1:0] coupled_units;

  assign coupled_units = {{2{coupled[2]}}, {2{coupled[1]}}, {2{coupled[0]}}};
  assign rd_mux = (reg_addr == ADDR_CFG0) ? cfg_r[0] :
    (reg_addr == ADDR_CFG1) ? cfg_r[1] :
    (reg_addr == ADDR_CFG2) ? cfg_r[2] :
    (reg_addr == ADDR_UNLOCK) ? {5'h00, unlock_r} :
    (reg_addr == ADDR_ACTIVE) ? {2'h0, active} :
    (reg_addr == ADDR_PAIRSTAT) ? {3'h0, two_pairs, pair_switch, 1'b0, pair_act} : 8'h00;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_rdata_r <= 8'h00;
      pwm_out_r <= 6'h00;
      hold_release_handshake_r <= 6'h00;
      unit_coupled_r <= 6'h00;
    end else begin
      reg_rdata_r <= reg_rd ? rd_mux : 8'h00;
      pwm_out_r <= pwm_nxt;
      hold_release_handshake_r <= rel;
      unit_coupled_r <= coupled_units;
    end
  end

  // ********************************
  // assertions
  // ********************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_release_partner_hi: assert property (
    coupled[2] & hold[4] & ~$past(hold[4]) |-> ##2 hold_release_handshake_r[5])
    else $error("partner of unit 4 not released");
  a_single_no_release: assert property (
    (pair_mode[2] == MODE_SINGLE) [*3] |-> ~hold_release_handshake_r[5] & ~hold_release_handshake_r[4])
    else $error("release issued in single mode");
  a_single_own_pwm: assert property (
    ~coupled[2] |=> pwm_out_r[4] == $past(unit_pwm[4]))
    else $error("single unit output not its own");
  a_separate_pwm: assert property (
    coupled[2] & ~drv[4] & ~drv[5] |=> pwm_out_r[5] == $past(unit_pwm[5]))
    else $error("separate output disturbed");
  a_merged_or: assert property (
    coupled[2] & drv[4] & ~drv[5] |=> pwm_out_r[4] == $past((unit_pwm[4] & active[4]) | (unit_pwm[5] & active[5])))
    else $error("merged output not gated or");
  a_merged_low_frozen: assert property (
    coupled[2] & drv[5] & ~drv[4] & hold[4] & hold[5] |=> ~pwm_out_r[5])
    else $error("merged output high with both frozen");
  a_cfg_frozen: assert property (
    reg_wr & (reg_addr == ADDR_CFG2) & pair_busy[2] |=> $stable(cfg_r[2]))
    else $error("config changed while enabled");
  a_unlock_live: assert property (
    unlock_wr |=> unlock_r == $past(reg_wdata[2:0]))
    else $error("unlock write lost");
  a_pairs_exclusive: assert property (
    ~(pair_act[0] & pair_act[1]))
    else $error("both pairs active");
  a_cross_switch: assert property (
    two_pairs & pair_switch & leave[0] & first_lo[1] |=> ##1 hold_release_handshake_r[2])
    else $error("pair switch did not hand over");
  a_read_active: assert property (
    reg_rd & (reg_addr == ADDR_ACTIVE) |=> reg_rdata_r == {2'h0, $past(active)})
    else $error("active status read wrong");

  c_handover: cover property (coupled[0] & hold[0] & ~$past(hold[0]) ##2 hold_release_handshake_r[1]);
  c_merged: cover property (coupled[0] & drv[0] & ~drv[1] & active[1] ##1 pwm_out_r[0]);
  c_pair_switch: cover property (two_pairs & leave[0]);
endmodule // cpx_expansion

// ### logic/cpx_pkg.sv
// constants shared by the coupled pwm expansion logic
package cpx_pkg;

  localparam int NUM_UNITS = 6;
  localparam int NUM_PAIRS = 3;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // global mode field encodings
  localparam logic [2:0] MODE_SINGLE = 3'h0;
  localparam logic [2:0] MODE_SYNC_PAIR = 3'h1;
  localparam logic [2:0] MODE_TWO_SYNC = 3'h2;
  localparam logic [2:0] MODE_TWO_ASYNC = 3'h3;
  localparam logic [2:0] MODE_EXT = 3'h4;
  localparam logic [2:0] MODE_ASYNC_PAIR = 3'h5;

  // unit_state code of the frozen state
  localparam logic [2:0] STATE_HOLD = 3'h5;

  // register offsets
  localparam logic [3:0] ADDR_CFG0 = 4'h0;
  localparam logic [3:0] ADDR_CFG1 = 4'h1;
  localparam logic [3:0] ADDR_CFG2 = 4'h2;
  localparam logic [3:0] ADDR_UNLOCK = 4'h3;
  localparam logic [3:0] ADDR_ACTIVE = 4'h4;
  localparam logic [3:0] ADDR_PAIRSTAT = 4'h5;

  // unit_config_register layout: lower unit then upper unit
  localparam int CFG_MODE_LO_POS = 0;
  localparam int CFG_DRV_LO_POS = 3;
  localparam int CFG_MODE_HI_POS = 4;
  localparam int CFG_DRV_HI_POS = 7;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [2:0] UNLOCK_RESET = 3'h0;

  // handover timing, in unit clock periods
  localparam int HANDOVER_LAT_TCK = 2;
  localparam int REENTER_MIN_TCK = 3;

endpackage

// ### logic/cpx_handover.sv
// hold-enter / hold-release handshake for one coupled pair
module cpx_handover (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic coupled,
  input wire logic allow,
  input wire logic hold_lo,
  input wire logic hold_hi,
  input wire logic ext_rel_lo,
  input wire logic ext_rel_hi,
  output logic rel_lo_r,
  output logic rel_hi_r,
  output logic first_lo_r,
  output logic leave
);
  logic hold_lo_d_r;
  logic hold_hi_d_r;
  logic enter_lo;
  logic enter_hi;
  logic rel_lo_nxt;
  logic rel_hi_nxt;
  logic first_lo_nxt;

  assign enter_lo = hold_lo & ~hold_lo_d_r;
  assign enter_hi = hold_hi & ~hold_hi_d_r;
  // entering unit frees its partner only while the pair holds control
  assign rel_lo_nxt = coupled & ((enter_hi & allow) | ext_rel_lo);
  assign rel_hi_nxt = coupled & ((enter_lo & allow) | ext_rel_hi);
  // control leaves the pair when it lost the pair switch
  assign leave = coupled & ~allow & (enter_lo | enter_hi);
  assign first_lo_nxt = (enter_hi & ~enter_lo) ? 1'b1 : (enter_lo & ~enter_hi) ? 1'b0 : first_lo_r;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hold_lo_d_r <= 1'b0;
      hold_hi_d_r <= 1'b0;
      rel_lo_r <= 1'b0;
      rel_hi_r <= 1'b0;
      first_lo_r <= 1'b1;
    end else begin
      hold_lo_d_r <= hold_lo;
      hold_hi_d_r <= hold_hi;
      rel_lo_r <= rel_lo_nxt;
      rel_hi_r <= rel_hi_nxt;
      first_lo_r <= first_lo_nxt;
    end
  end
endmodule // cpx_handover

// ### logic/cpx_pair_merge.sv
// merged-drive output selection for two units
module cpx_pair_merge (
  input wire logic merge_en,
  input wire logic pwm_a,
  input wire logic pwm_b,
  input wire logic act_a,
  input wire logic act_b,
  input wire logic drv_a,
  input wire logic drv_b,
  output logic out_a,
  output logic out_b
);
  logic merged;
  logic sel_a;
  logic sel_b;

  // each term gated by its owner being active; low when both frozen
  assign merged = (pwm_a & act_a) | (pwm_b & act_b);
  assign sel_a = merge_en & drv_a & ~drv_b;
  assign sel_b = merge_en & drv_b & ~drv_a;
  assign out_a = sel_a ? merged : pwm_a;
  assign out_b = sel_b ? merged : pwm_b;
endmodule // cpx_pair_merge

// ### test/cpx_unit_model.sv
// behavioural model of the six partner pwm state-machine units
module cpx_unit_model (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [5:0] enable,
  input wire logic [5:0] start_hold,
  input wire logic [5:0] release_in,
  input wire logic [5:0] rand_bits,
  input wire logic [3:0] run_len,
  output logic [17:0] unit_state,
  output logic [5:0] unit_pwm
);
  import cpx_pkg::*;
  int cnt [6];
  // all units step on the one shared clock
  always_ff @(posedge ref_clk) begin
    unit_pwm <= rand_bits;
    for (int u = 0; u < 6; u++) begin
      if (sys_rst || !enable[u]) begin
        unit_state[3*u+:3] <= 3'h4;
        cnt[u] <= 0;
      end else if (unit_state[3*u+:3] == 3'h4) begin
        unit_state[3*u+:3] <= start_hold[u] ? STATE_HOLD : 3'h0;
      end else if (unit_state[3*u+:3] == STATE_HOLD) begin
        if (release_in[u]) begin
          unit_state[3*u+:3] <= 3'h0;
          cnt[u] <= 0;
        end
      end else if (cnt[u] >= 3 + run_len) begin
        unit_state[3*u+:3] <= STATE_HOLD;
      end else begin
        cnt[u] <= cnt[u] + 1;
        unit_state[3*u+:3] <= 3'(cnt[u] % 4);
      end
    end
  end
endmodule // cpx_unit_model

// ### test/cpx_expansion_tb.sv
// self-checking bench for the coupled pwm expansion block
module cpx_expansion_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import cpx_pkg::*;
  logic ref_clk, sys_rst, reg_wr, reg_rd, pair_switch;
  logic [3:0] reg_addr, run_len;
  logic [7:0] reg_wdata, reg_rdata_r;
  logic [5:0] unit_enable, unit_pwm, pwm_out_r, rel, unit_coupled_r, start_hold, rand_bits, rel_mask;
  logic [17:0] unit_state;
  logic [7:0] cfg [3];
  logic [2:0] unl, md;
  logic [1:0] dv;
  int bad_count, check_count, seed;

  cpx_expansion cpx_expansion_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
    .unit_enable(unit_enable), .unit_state(unit_state), .unit_pwm(unit_pwm), .pair_switch(pair_switch),
    .pwm_out_r(pwm_out_r), .hold_release_handshake_r(rel), .unit_coupled_r(unit_coupled_r));
  cpx_unit_model cpx_unit_model_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .enable(unit_enable),
    .start_hold(start_hold), .release_in(rel), .rand_bits(rand_bits), .run_len(run_len),
    .unit_state(unit_state), .unit_pwm(unit_pwm));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) rand_bits <= 6'($random(seed));

  // ****************************************
  // reference model and bus tasks
  // ****************************************
  function automatic logic hold(input int u);
    return unit_state[3*u+:3] == STATE_HOLD;
  endfunction
  function automatic logic cpl(input int k);
    return cfg[k][2:0] inside {MODE_SYNC_PAIR, MODE_TWO_SYNC, MODE_TWO_ASYNC, MODE_ASYNC_PAIR} && !unl[k];
  endfunction
  function automatic logic [5:0] exp_pwm();
    logic [5:0] o;
    o = unit_pwm;
    for (int k = 0; k < 3; k++)
      if (cpl(k) && (cfg[k][3] ^ cfg[k][7]))
        o[cfg[k][7] ? 2*k+1 : 2*k] = (unit_pwm[2*k] & !hold(2*k)) | (unit_pwm[2*k+1] & !hold(2*k+1));
    return o;
  endfunction
  task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string what);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(negedge ref_clk);
    if (a == ADDR_ACTIVE) e = {2'h0, ~{hold(5), hold(4), hold(3), hold(2), hold(1), hold(0)}};
    if (a == ADDR_PAIRSTAT) e = {3'h0, cpl(0) && cfg[0][2:1] == 2'h1, pair_switch, 1'b0,
      (!hold(2) || !hold(3)) && hold(0) && hold(1), (!hold(0) || !hold(1)) && hold(2) && hold(3)};
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    check(what, e, reg_rdata_r);
    @(negedge ref_clk);
    check("idle read data", 8'h00, reg_rdata_r);
  endtask
  task automatic run(input int n);
    logic [5:0] pq, r1, r2;
    logic [17:0] prev;
    @(negedge ref_clk);
    prev = unit_state;
    for (int c = 0; c < n; c++) begin
      @(negedge ref_clk);
      if (c > 0) check("pwm pins", {2'h0, pq}, {2'h0, pwm_out_r});
      if (c > 1) check("release", {2'h0, r2 & rel_mask}, {2'h0, rel & rel_mask});
      r2 = r1;
      r1 = 6'h00;
      for (int u = 0; u < 6; u++)
        if (hold(u) && prev[3*u+:3] != STATE_HOLD && cpl(u / 2)) r1[u ^ 1] = 1'b1;
      pq = exp_pwm();
      prev = unit_state;
    end
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    seed = 63;
    sys_rst = 1'b1;
    {reg_wr, reg_rd, pair_switch, reg_addr, reg_wdata, unit_enable, start_hold, run_len, rel_mask} = '0;
    bad_count = 0;
    check_count = 0;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(negedge ref_clk);
    check("outputs in reset", 8'h00, {2'h0, pwm_out_r | rel | unit_coupled_r});
    for (int a = 0; a < 4; a++) rd(4'(a), 8'h00, "register reset");
    for (int r = 0; r < 10; r++) begin
      unl = 3'($random(seed) & $random(seed));
      if (r > 7) unl[1:0] = 2'h0;
      for (int k = 0; k < 3; k++) begin
        md = 3'($random(seed)) & 3'h5;
        if (r > 7 && k < 2) md = 3'(r - 6);
        dv = (md == MODE_SYNC_PAIR || md == MODE_ASYNC_PAIR) ? 2'($unsigned($random(seed)) % 3) : 2'h0;
        cfg[k] = {dv[1], md, dv[0], md};
        wr(4'(k), cfg[k]);
      end
      wr(ADDR_UNLOCK, {5'h0, unl});
      @(posedge ref_clk);
      start_hold <= {cpl(2), 1'b0, cpl(1), r > 7, cpl(0), 1'b0};
      rel_mask <= (r > 7) ? 6'h30 : 6'h3F;
      pair_switch <= 1'($random(seed));
      run_len <= 4'($random(seed));
      unit_enable <= 6'h3F;
      repeat (5) @(negedge ref_clk);
      check("coupled", {2'h0, cpl(2), cpl(2), cpl(1), cpl(1), cpl(0), cpl(0)}, {2'h0, unit_coupled_r});
      run(150);
      wr(ADDR_CFG0, ~cfg[0]);
      rd(ADDR_CFG0, cfg[0], "frozen config");
      wr(ADDR_ACTIVE, 8'hFF);
      rd(ADDR_ACTIVE, 8'h00, "active units");
      rd(ADDR_PAIRSTAT, 8'h00, "pair status");
      unl = ~unl;
      wr(ADDR_UNLOCK, {5'h0, unl});
      rd(ADDR_UNLOCK, {5'h0, unl}, "unlock");
      rd(4'hF, 8'h00, "unmapped");
      @(posedge ref_clk);
      unit_enable <= 6'h00;
      repeat (3) @(posedge ref_clk);
    end
    give_verdict();
  end
  // hang guard
  initial begin
    #10000000;
    bad_count++;
    give_verdict();
  end
endmodule // cpx_expansion_tb
